// ==== core/dtppl_latch.v ====
// Two-channel probe position latch with object-style register port
`timescale 1ns/1ps
`include "dtppl_regs.vh"

module dtppl_latch (
	input  wire        clk_sys,          // System clock, 100 MHz
	input  wire        rst,              // Asynchronous reset, active high
	input  wire        probe_input_one,  // External probe input one, asynchronous
	input  wire        probe_input_two,  // External probe input two, asynchronous
	input  wire        index_pulse,      // Encoder index pulse, asynchronous
	input  wire [31:0] actual_position,  // Actual position, signed, clk_sys domain
	input  wire        obj_wr,           // Object write strobe, one cycle
	input  wire        obj_rd,           // Object read strobe, one cycle
	input  wire [15:0] obj_index,        // Object index
	input  wire [7:0]  obj_sub,          // Object sub-index
	input  wire [31:0] obj_wdata,        // Write data, low 16 bits used
	output reg  [31:0] obj_rdata,        // Read data, valid with obj_ack
	output reg         obj_ack,          // Access done, one cycle
	output reg         obj_err           // Access refused, with obj_ack
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	reg  [2:0]  sync_a_reg;    // First stage, read only by second stage
	reg  [2:0]  sync_b_reg;    // Second stage, safe to use
	wire [2:0]  pin_raw;

	assign pin_raw = {index_pulse, probe_input_two, probe_input_one};

	// Two flops on every pin before any logic looks at it
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync_a_reg <= 3'h0;
			sync_b_reg <= 3'h0;
		end else begin
			sync_a_reg <= pin_raw;
			sync_b_reg <= sync_a_reg;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	reg  [15:0] control_reg;
	reg  [15:0] pol_one_reg;
	reg  [15:0] pol_two_reg;
	reg  [`DTPPL_COMP_W-1:0] comp_one_reg;
	reg  [`DTPPL_COMP_W-1:0] comp_two_reg;
	reg  [31:0] din_reg;
	reg  [31:0] pos_prev_reg;

	wire        hit_pol_one;
	wire        hit_pol_two;
	wire        hit_comp_one;
	wire        hit_comp_two;
	wire        hit_control;
	wire        ctl_wr;

	assign hit_pol_one  = (obj_index == `DTPPL_IDX_POLARITY) && (obj_sub == `DTPPL_SUB_ZERO);
	assign hit_pol_two  = (obj_index == `DTPPL_IDX_POLARITY) && (obj_sub == `DTPPL_SUB_ONE);
	assign hit_comp_one = (obj_index == `DTPPL_IDX_COMP_ONE) && (obj_sub == `DTPPL_SUB_ZERO);
	assign hit_comp_two = (obj_index == `DTPPL_IDX_COMP_TWO) && (obj_sub == `DTPPL_SUB_ZERO);
	assign hit_control  = (obj_index == `DTPPL_IDX_CONTROL) && (obj_sub == `DTPPL_SUB_ZERO);
	assign ctl_wr       = obj_wr && hit_control;

	// Writable objects; compensation keeps only its documented 15-bit range
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			control_reg  <= `DTPPL_RST_CONTROL;
			pol_one_reg  <= `DTPPL_RST_POLARITY;
			pol_two_reg  <= `DTPPL_RST_POLARITY;
			comp_one_reg <= `DTPPL_RST_COMP;
			comp_two_reg <= `DTPPL_RST_COMP;
		end else if (obj_wr) begin
			if (hit_pol_one) begin
				pol_one_reg <= obj_wdata[15:0];
			end else if (hit_pol_two) begin
				pol_two_reg <= obj_wdata[15:0];
			end else if (hit_comp_one) begin
				comp_one_reg <= obj_wdata[`DTPPL_COMP_W-1:0];
			end else if (hit_comp_two) begin
				comp_two_reg <= obj_wdata[`DTPPL_COMP_W-1:0];
			end else if (hit_control) begin
				control_reg <= obj_wdata[15:0];
			end
		end
	end

	// Live input levels and last position for speed estimate
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			din_reg      <= `DTPPL_RST_WORD;
			pos_prev_reg <= `DTPPL_RST_WORD;
		end else begin
			din_reg                 <= `DTPPL_RST_WORD;
			din_reg[`DTPPL_DIN_ONE] <= sync_b_reg[0];
			din_reg[`DTPPL_DIN_TWO] <= sync_b_reg[1];
			pos_prev_reg            <= actual_position;
		end
	end

	// ****************************************************************
	// Per-channel capture logic
	// ****************************************************************
	wire [1:0]   inv_sel;      // High when a channel's polarity is reversed
	wire [29:0]  comp_bus;     // Compensation of each channel, 15 bits apiece
	wire [127:0] pos_bus;      // Rise and fall positions, 64 bits per channel
	wire [127:0] cnt_bus;      // Rise and fall counters, 64 bits per channel
	wire [5:0]   stat_bus;     // Enable, rise done, fall done per channel
	wire signed [31:0] pos_delta;

	// Setting bit set means the channel is not reversed
	assign inv_sel   = {~pol_two_reg[`DTPPL_POL_NOINV], ~pol_one_reg[`DTPPL_POL_NOINV]};
	assign comp_bus  = {comp_two_reg, comp_one_reg};
	assign pos_delta = $signed(actual_position - pos_prev_reg);

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			wire [7:0]  cbyte;
			wire        en;
			wire        cont;
			wire        use_index;
			wire        rise_en;
			wire        fall_en;
			wire        src_lvl;
			wire        pol_lvl;
			wire        edge_r;
			wire        edge_f;
			wire        acc_r;
			wire        acc_f;
			wire signed [47:0] prod;
			wire signed [55:0] corr;
			wire [31:0] comp_pos;
			wire [`DTPPL_COMP_W-1:0] comp_val;
			wire        wr_src;
			wire        wr_lvl;
			reg         lvl_reg;
			reg         armed_reg;
			reg         done_r_reg;
			reg         done_f_reg;
			reg  [31:0] pos_r_reg;
			reg  [31:0] pos_f_reg;
			reg  [31:0] cnt_r_reg;
			reg  [31:0] cnt_f_reg;

			assign cbyte     = control_reg[ch*`DTPPL_CB_WIDTH +: `DTPPL_CB_WIDTH];
			assign en        = cbyte[`DTPPL_CB_EN];
			assign cont      = cbyte[`DTPPL_CB_MODE];
			assign use_index = cbyte[`DTPPL_CB_SRC];
			assign rise_en   = cbyte[`DTPPL_CB_RISE];
			assign fall_en   = cbyte[`DTPPL_CB_FALL];

			// Source select: own probe input or shared index pulse
			assign src_lvl = use_index ? sync_b_reg[2] : sync_b_reg[ch];
			assign pol_lvl = src_lvl ^ inv_sel[ch];
			assign edge_r  = pol_lvl & ~lvl_reg;
			assign edge_f  = ~pol_lvl & lvl_reg;

			// Level of the source being written; a source switch must not pose as an edge
			assign wr_src  = obj_wdata[ch*`DTPPL_CB_WIDTH + `DTPPL_CB_SRC];
			assign wr_lvl  = (wr_src ? sync_b_reg[2] : sync_b_reg[ch]) ^ inv_sel[ch];

			// Single mode takes one capture; falling only if rising is off
			assign acc_r = en & rise_en & edge_r & (cont | armed_reg);
			assign acc_f = en & fall_en & edge_f & (cont | (armed_reg & ~rise_en));

			// Back the position up by the distance moved during the set delay
			assign comp_val = comp_bus[ch*`DTPPL_COMP_W +: `DTPPL_COMP_W];
			assign prod     = pos_delta * $signed({1'b0, comp_val});
			assign corr     = (prod * `DTPPL_COMP_STEP_NS) / `DTPPL_CLK_PERIOD_NS;
			assign comp_pos = actual_position - corr[31:0];

			// Level tracking and single-shot arming
			always @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					lvl_reg   <= 1'b0;
					armed_reg <= 1'b0;
				end else begin
					// Pin edges in the write cycle are judged under the old setting; the new source starts from its present level
					if (ctl_wr) begin
						lvl_reg <= wr_lvl;
					end else begin
						lvl_reg <= pol_lvl;
					end
					if (ctl_wr) begin
						armed_reg <= 1'b1;
					end else if (!cont && (acc_r || acc_f)) begin
						armed_reg <= 1'b0;
					end
				end
			end

			// Positions survive a control write; counters and executed flags restart
			always @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					pos_r_reg <= `DTPPL_RST_WORD;
					pos_f_reg <= `DTPPL_RST_WORD;
				end else begin
					if (acc_r) begin
						pos_r_reg <= comp_pos;
					end
					if (acc_f) begin
						pos_f_reg <= comp_pos;
					end
				end
			end

			// Counters and executed flags; a coincident capture wins over restart
			always @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					cnt_r_reg  <= `DTPPL_RST_WORD;
					cnt_f_reg  <= `DTPPL_RST_WORD;
					done_r_reg <= 1'b0;
					done_f_reg <= 1'b0;
				end else if (ctl_wr) begin
					cnt_r_reg  <= {31'h0000_0000, acc_r};
					cnt_f_reg  <= {31'h0000_0000, acc_f};
					done_r_reg <= acc_r;
					done_f_reg <= acc_f;
				end else begin
					if (acc_r) begin
						cnt_r_reg  <= cnt_r_reg + 32'h0000_0001;
						done_r_reg <= 1'b1;
					end
					if (acc_f) begin
						cnt_f_reg  <= cnt_f_reg + 32'h0000_0001;
						done_f_reg <= 1'b1;
					end
				end
			end

			assign pos_bus[ch*64 +: 64] = {pos_f_reg, pos_r_reg};
			assign cnt_bus[ch*64 +: 64] = {cnt_f_reg, cnt_r_reg};
			assign stat_bus[ch*3 +: 3]  = {done_f_reg, done_r_reg, en};
		end
	endgenerate

	// ****************************************************************
	// Status word and read port
	// ****************************************************************
	reg  [15:0] status_word;
	reg  [31:0] rd_next;
	reg         err_next;

	// Status word is rebuilt from live channel state, so it follows every write
	always @* begin
		status_word = 16'h0000;
		status_word[`DTPPL_ST_EN]                 = stat_bus[0];
		status_word[`DTPPL_ST_RISE]               = stat_bus[1];
		status_word[`DTPPL_ST_FALL]               = stat_bus[2];
		status_word[`DTPPL_ST_BYTE+`DTPPL_ST_EN]  = stat_bus[3];
		status_word[`DTPPL_ST_BYTE+`DTPPL_ST_RISE] = stat_bus[4];
		status_word[`DTPPL_ST_BYTE+`DTPPL_ST_FALL] = stat_bus[5];
	end

	// Read decode; writes to read-only or unknown objects are refused
	always @* begin
		rd_next  = `DTPPL_RST_WORD;
		err_next = 1'b0;
		if (hit_pol_one) begin
			rd_next = {16'h0000, pol_one_reg};
		end else if (hit_pol_two) begin
			rd_next = {16'h0000, pol_two_reg};
		end else if (hit_comp_one) begin
			rd_next = {17'h0_0000, comp_one_reg};
		end else if (hit_comp_two) begin
			rd_next = {17'h0_0000, comp_two_reg};
		end else if (hit_control) begin
			rd_next = {16'h0000, control_reg};
		end else if (obj_sub != `DTPPL_SUB_ZERO) begin
			err_next = 1'b1;
		end else if (obj_index == `DTPPL_IDX_STATUS) begin
			rd_next  = {16'h0000, status_word};
			err_next = obj_wr;
		end else if (obj_index == `DTPPL_IDX_POS_1R) begin
			rd_next  = pos_bus[31:0];
			err_next = obj_wr;
		end else if (obj_index == `DTPPL_IDX_POS_1F) begin
			rd_next  = pos_bus[63:32];
			err_next = obj_wr;
		end else if (obj_index == `DTPPL_IDX_POS_2R) begin
			rd_next  = pos_bus[95:64];
			err_next = obj_wr;
		end else if (obj_index == `DTPPL_IDX_POS_2F) begin
			rd_next  = pos_bus[127:96];
			err_next = obj_wr;
		end else if (obj_index == `DTPPL_IDX_CNT_1R) begin
			rd_next  = cnt_bus[31:0];
			err_next = obj_wr;
		end else if (obj_index == `DTPPL_IDX_CNT_1F) begin
			rd_next  = cnt_bus[63:32];
			err_next = obj_wr;
		end else if (obj_index == `DTPPL_IDX_CNT_2R) begin
			rd_next  = cnt_bus[95:64];
			err_next = obj_wr;
		end else if (obj_index == `DTPPL_IDX_CNT_2F) begin
			rd_next  = cnt_bus[127:96];
			err_next = obj_wr;
		end else if (obj_index == `DTPPL_IDX_DIN) begin
			rd_next  = din_reg;
			err_next = obj_wr;
		end else begin
			err_next = 1'b1;
		end
	end

	// Answer one cycle after the strobe; write answers carry no data
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			obj_rdata <= `DTPPL_RST_WORD;
			obj_ack   <= 1'b0;
			obj_err   <= 1'b0;
		end else begin
			obj_ack   <= obj_wr | obj_rd;
			obj_err   <= (obj_wr | obj_rd) & err_next;
			obj_rdata <= (obj_rd && !obj_wr && !err_next) ? rd_next : `DTPPL_RST_WORD;
		end
	end

endmodule

// ==== core/dtppl_regs.vh ====
// Object indices, field positions, reset values and timing constants of the probe latch
`ifndef DTPPL_REGS_VH
`define DTPPL_REGS_VH

// ****************************************************************
// Object indices and sub-indices
// ****************************************************************
`define DTPPL_IDX_POLARITY   16'h2007
`define DTPPL_IDX_COMP_ONE   16'h2533
`define DTPPL_IDX_COMP_TWO   16'h2534
`define DTPPL_IDX_CONTROL    16'h60B8
`define DTPPL_IDX_STATUS     16'h60B9
`define DTPPL_IDX_POS_1R     16'h60BA
`define DTPPL_IDX_POS_1F     16'h60BB
`define DTPPL_IDX_POS_2R     16'h60BC
`define DTPPL_IDX_POS_2F     16'h60BD
`define DTPPL_IDX_CNT_1R     16'h60D5
`define DTPPL_IDX_CNT_1F     16'h60D6
`define DTPPL_IDX_CNT_2R     16'h60D7
`define DTPPL_IDX_CNT_2F     16'h60D8
`define DTPPL_IDX_DIN        16'h60FD
`define DTPPL_SUB_ZERO       8'h00
`define DTPPL_SUB_ONE        8'h01

// ****************************************************************
// Control byte fields (same layout in each byte)
// ****************************************************************
`define DTPPL_CB_WIDTH       8
`define DTPPL_CB_EN          0
`define DTPPL_CB_MODE        1
`define DTPPL_CB_SRC         2
`define DTPPL_CB_RISE        4
`define DTPPL_CB_FALL        5

// ****************************************************************
// Status word fields, digital input word fields
// ****************************************************************
`define DTPPL_ST_BYTE        8
`define DTPPL_ST_EN          0
`define DTPPL_ST_RISE        1
`define DTPPL_ST_FALL        2
`define DTPPL_DIN_ONE        26
`define DTPPL_DIN_TWO        27

// ****************************************************************
// Reset values and field widths
// ****************************************************************
`define DTPPL_RST_CONTROL    16'h0000
`define DTPPL_RST_POLARITY   16'h0001
`define DTPPL_RST_COMP       15'h0000
`define DTPPL_RST_WORD       32'h0000_0000
`define DTPPL_POL_NOINV      0
`define DTPPL_COMP_W         15

// ****************************************************************
// Timing: compensation step and clock period
// ****************************************************************
`define DTPPL_COMP_STEP_NS   25
`define DTPPL_CLK_PERIOD_NS  10

`endif

// ==== verif/dtppl_axis_model.sv ====
// Axis and probe pin model: position ramp and registered pin levels
`timescale 1ns/1ps
module dtppl_axis_model #(
	parameter logic [31:0] START = 32'h0000_1000  // Arbitrary start position
) (
	input  wire        clk_sys,          // System clock
	input  wire        rst,              // Reset, active high
	input  wire [31:0] speed,            // Position step per cycle
	input  wire [2:0]  lvl,              // Wanted index, pin two, pin one
	output reg  [31:0] actual_position,  // Position to the latch
	output reg         probe_input_one,  // Probe pin one
	output reg         probe_input_two,  // Probe pin two
	output reg         index_pulse       // Encoder index
);
	// Pins move one cycle after the request, like a real switch behind a flop
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			actual_position <= START;
			{index_pulse, probe_input_two, probe_input_one} <= 3'h0;
		end else begin
			actual_position <= actual_position + speed;
			{index_pulse, probe_input_two, probe_input_one} <= lvl;
		end
	end
endmodule

// ==== verif/dtppl_chk.sv ====
// Concurrent checks on the object port and input word of the probe latch
`timescale 1ns/1ps
`include "dtppl_regs.vh"
module dtppl_chk (
	input wire        clk_sys,          // System clock
	input wire        rst,              // Asynchronous reset, active high
	input wire        probe_input_one,  // Probe pin one
	input wire        probe_input_two,  // Probe pin two
	input wire        index_pulse,      // Encoder index
	input wire [31:0] actual_position,  // Position feed
	input wire        obj_wr,           // Write strobe
	input wire        obj_rd,           // Read strobe
	input wire [15:0] obj_index,        // Object index
	input wire [7:0]  obj_sub,          // Sub-index
	input wire [31:0] obj_wdata,        // Write data
	input wire [31:0] obj_rdata,        // Read data
	input wire        obj_ack,          // Access done
	input wire        obj_err           // Access refused
);
	reg [2:0] stab_reg;  // Cycles both pins held still

	// ****************************************************************
	// Helper logic
	// ****************************************************************
	// Input word trails the pins by the sync stages, so wait for a quiet spell
	always @(posedge clk_sys or posedge rst) begin
		if (rst) stab_reg <= 3'h0;
		else if ($changed(probe_input_one) || $changed(probe_input_two)) stab_reg <= 3'h0;
		else if (stab_reg != 3'h7) stab_reg <= stab_reg + 3'h1;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_ack; (obj_wr || obj_rd) |=> obj_ack; endproperty
	a_ack: assert property (p_ack) else $error("strobe not answered next cycle");
	property p_quiet; !(obj_wr || obj_rd) |=> !obj_ack && !obj_err; endproperty
	a_quiet: assert property (p_quiet) else $error("answer without strobe");
	property p_err_ack; obj_err |-> obj_ack; endproperty
	a_err_ack: assert property (p_err_ack) else $error("refusal outside answer");
	property p_idle_zero; !obj_ack |-> obj_rdata == 32'h0; endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data not zero when idle");
	property p_status_ro; obj_wr && obj_index == `DTPPL_IDX_STATUS |=> obj_err; endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write taken");
	property p_pos_ro;
		obj_wr && obj_index >= `DTPPL_IDX_POS_1R && obj_index <= `DTPPL_IDX_POS_2F |=> obj_err;
	endproperty
	a_pos_ro: assert property (p_pos_ro) else $error("position write taken");
	property p_cnt_ro;
		obj_wr && obj_index >= `DTPPL_IDX_CNT_1R && obj_index <= `DTPPL_IDX_CNT_2F |=> obj_err;
	endproperty
	a_cnt_ro: assert property (p_cnt_ro) else $error("counter write taken");
	property p_pol_sub;
		obj_rd && obj_index == `DTPPL_IDX_POLARITY && obj_sub == `DTPPL_SUB_ONE
			|=> obj_ack && !obj_err;
	endproperty
	a_pol_sub: assert property (p_pol_sub) else $error("second polarity refused");
	property p_din;
		obj_rd && obj_index == `DTPPL_IDX_DIN && obj_sub == 8'h00 && stab_reg >= 3'h5
			|=> obj_rdata[27:26] == {$past(probe_input_two), $past(probe_input_one)};
	endproperty
	a_din: assert property (p_din) else $error("input word level wrong");
endmodule

bind dtppl_latch dtppl_chk u_chk (.clk_sys(clk_sys), .rst(rst),
	.probe_input_one(probe_input_one), .probe_input_two(probe_input_two),
	.index_pulse(index_pulse), .actual_position(actual_position), .obj_wr(obj_wr),
	.obj_rd(obj_rd), .obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata),
	.obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));

// ==== verif/dtppl_latch_tb.sv ====
// Self-checking bench for the probe latch
`timescale 1ns/1ps
`include "dtppl_regs.vh"
module dtppl_latch_tb;
	typedef struct packed {
		logic        wr;
		logic [15:0] idx;
		logic [7:0]  sub;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic        err;
	} dtppl_row_t;
	reg          clk_sys, rst, obj_wr, obj_rd;
	reg  [15:0]  obj_index;
	reg  [7:0]   obj_sub;
	reg  [31:0]  obj_wdata, speed;
	reg  [2:0]   lvl;
	wire [31:0]  obj_rdata, actual_position;
	wire         obj_ack, obj_err, probe_input_one, probe_input_two, index_pulse;
	int          num_errors = 0, samples_checked = 0, cycles = 0;
	logic [31:0] q, a;
	logic        e;
	dtppl_row_t  rows [0:13];

	dtppl_latch DUT (.clk_sys(clk_sys), .rst(rst), .probe_input_one(probe_input_one),
		.probe_input_two(probe_input_two), .index_pulse(index_pulse),
		.actual_position(actual_position), .obj_wr(obj_wr), .obj_rd(obj_rd),
		.obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata),
		.obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));
	dtppl_axis_model u_axis (.clk_sys(clk_sys), .rst(rst), .speed(speed), .lvl(lvl),
		.actual_position(actual_position), .probe_input_one(probe_input_one),
		.probe_input_two(probe_input_two), .index_pulse(index_pulse));

	// ****************************************************************
	// Clock, watchdog and tasks
	// ****************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Whole run is under a thousand cycles; the ceiling leaves ample slack
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			results();
		end
	end
	task results;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Strobe for one cycle; answer is sampled at the edge after it shows
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d);
		@(posedge clk_sys);
		obj_wr <= w;
		obj_rd <= !w;
		obj_index <= i;
		obj_sub <= s;
		obj_wdata <= d;
		@(posedge clk_sys);
		obj_wr <= 1'b0;
		obj_rd <= 1'b0;
		@(posedge clk_sys);
		q = obj_rdata;
		e = obj_err;
		chk({31'h0, obj_ack}, 32'h1);
	endtask
	task automatic rd(input logic [15:0] i, input logic [31:0] exp);
		acc(1'b0, i, 8'h00, 32'h0);
		chk(q, exp);
	endtask
	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		acc(1'b1, i, 8'h00, d);
	endtask
	// Position is noted at the edge that requests the pin change
	task automatic pin(input int k, input logic v);
		@(posedge clk_sys);
		a = actual_position;
		lvl[k] <= v;
		repeat (8) @(posedge clk_sys);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{rst, obj_wr, obj_rd, obj_index, obj_sub, obj_wdata, speed, lvl} = {1'b1, 93'h0};
		rows[0]  = '{1'b0, `DTPPL_IDX_POLARITY, 8'h00, 32'h0, 32'h1, 1'b0};
		rows[1]  = '{1'b0, `DTPPL_IDX_POLARITY, 8'h01, 32'h0, 32'h1, 1'b0};
		rows[2]  = '{1'b0, `DTPPL_IDX_COMP_ONE, 8'h00, 32'h0, 32'h0, 1'b0};
		rows[3]  = '{1'b0, `DTPPL_IDX_CONTROL, 8'h00, 32'h0, 32'h0, 1'b0};
		rows[4]  = '{1'b0, `DTPPL_IDX_STATUS, 8'h00, 32'h0, 32'h0, 1'b0};
		rows[5]  = '{1'b0, `DTPPL_IDX_DIN, 8'h00, 32'h0, 32'h0, 1'b0};
		rows[6]  = '{1'b1, `DTPPL_IDX_COMP_ONE, 8'h00, 32'h7FFF, 32'h0, 1'b0};
		rows[7]  = '{1'b0, `DTPPL_IDX_COMP_ONE, 8'h00, 32'h0, 32'h7FFF, 1'b0};
		rows[8]  = '{1'b1, `DTPPL_IDX_STATUS, 8'h00, 32'h5, 32'h0, 1'b1};
		rows[9]  = '{1'b1, `DTPPL_IDX_POS_1R, 8'h00, 32'h5, 32'h0, 1'b1};
		rows[10] = '{1'b1, `DTPPL_IDX_CNT_1R, 8'h00, 32'h5, 32'h0, 1'b1};
		rows[11] = '{1'b0, 16'h1234, 8'h00, 32'h0, 32'h0, 1'b1};
		rows[12] = '{1'b0, `DTPPL_IDX_CONTROL, 8'h01, 32'h0, 32'h0, 1'b1};
		rows[13] = '{1'b1, `DTPPL_IDX_POLARITY, 8'h01, 32'h1, 32'h0, 1'b0};
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		for (int n = 0; n < 4; n++) rd(`DTPPL_IDX_POS_1R + 16'(n), 32'h0);
		for (int n = 0; n < 4; n++) rd(`DTPPL_IDX_CNT_1R + 16'(n), 32'h0);
		for (int n = 0; n < 14; n++) begin
			acc(rows[n].wr, rows[n].idx, rows[n].sub, rows[n].wdata);
			chk(q, rows[n].rdata);
			chk({31'h0, e}, {31'h0, rows[n].err});
		end
		$display("test register table done");
		// Polarity stays at its default before enabling, continuous on both edges
		wr(`DTPPL_IDX_CONTROL, 32'h0033);
		pin(0, 1'b1);
		pin(0, 1'b0);
		pin(0, 1'b1);
		rd(`DTPPL_IDX_CNT_1R, 32'h2);
		rd(`DTPPL_IDX_CNT_1F, 32'h1);
		rd(`DTPPL_IDX_POS_1F, u_axis.START);
		rd(`DTPPL_IDX_STATUS, 32'h0007);
		$display("test continuous capture done");
		// Channel two on the index, single mode with both edges asked for
		wr(`DTPPL_IDX_CONTROL, 32'h3500);
		pin(2, 1'b1);
		pin(2, 1'b0);
		pin(2, 1'b1);
		rd(`DTPPL_IDX_CNT_2R, 32'h1);
		rd(`DTPPL_IDX_CNT_2F, 32'h0);
		rd(`DTPPL_IDX_CNT_1R, 32'h0);
		rd(`DTPPL_IDX_STATUS, 32'h0300);
		wr(`DTPPL_IDX_CONTROL, 32'h3500);
		rd(`DTPPL_IDX_CNT_2R, 32'h0);
		rd(`DTPPL_IDX_STATUS, 32'h0100);
		pin(2, 1'b0);
		pin(2, 1'b1);
		rd(`DTPPL_IDX_CNT_2R, 32'h1);
		$display("test single capture done");
		// Channel one inverted on the index: a falling index is a rising probe
		acc(1'b1, `DTPPL_IDX_POLARITY, 8'h00, 32'h0);
		wr(`DTPPL_IDX_CONTROL, 32'h0017);
		pin(2, 1'b0);
		rd(`DTPPL_IDX_CNT_1R, 32'h1);
		pin(2, 1'b1);
		rd(`DTPPL_IDX_CNT_1R, 32'h1);
		$display("test polarity done");
		// Moving axis: capture edge sees four steps past a, less speed times 25-cycle delay
		wr(`DTPPL_IDX_COMP_TWO, 32'hA);
		speed <= 32'h4;
		wr(`DTPPL_IDX_CONTROL, 32'h1300);
		pin(1, 1'b1);
		rd(`DTPPL_IDX_POS_2R, a + 32'd4 * 32'd4 - 32'd4 * 32'd10 * 32'd25 / 32'd10);
		$display("test compensation done");
		// Input word follows the pins with every channel off
		wr(`DTPPL_IDX_CONTROL, 32'h0);
		pin(1, 1'b0);
		rd(`DTPPL_IDX_DIN, 32'h0400_0000);
		pin(0, 1'b0);
		pin(1, 1'b1);
		rd(`DTPPL_IDX_DIN, 32'h0800_0000);
		$display("test input word done");
		// Channel two moves from a high pin to a low index: no edge; single, falling only
		pin(2, 1'b0);
		wr(`DTPPL_IDX_CONTROL, 32'h2500);
		rd(`DTPPL_IDX_CNT_2F, 32'h0);
		pin(2, 1'b1);
		pin(2, 1'b0);
		pin(2, 1'b1);
		pin(2, 1'b0);
		rd(`DTPPL_IDX_CNT_2F, 32'h1);
		rd(`DTPPL_IDX_STATUS, 32'h0500);
		$display("test source switch done");
		// Reset in mid-run clears captures, counters and compensation
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd(`DTPPL_IDX_POS_2R, 32'h0);
		rd(`DTPPL_IDX_CNT_2R, 32'h0);
		rd(`DTPPL_IDX_COMP_TWO, 32'h0);
		$display("test second reset done");
		results();
	end
endmodule
